// ==== rtl/mcuit_defines.svh ====
`ifndef MCUIT_DEFINES_SVH
`define MCUIT_DEFINES_SVH

// system clock cycles in one instruction cycle
`define MCUIT_PHASES        4

// instruction word fields
`define MCUIT_OP_MSB        15
`define MCUIT_OP_LSB        11
`define MCUIT_BIT_MSB       10
`define MCUIT_BIT_LSB       8
`define MCUIT_DST_BIT       8
`define MCUIT_OPND_MSB      7
`define MCUIT_TGT_MSB       10

// special data memory addresses
`define MCUIT_PCL_ADDR      8'h06
`define MCUIT_TBLP_ADDR     8'h07
`define MCUIT_TBLH_ADDR     8'h08

// reset values
`define MCUIT_PC_RST        11'h000
`define MCUIT_ACC_RST       8'h00

// opcodes, five bits
`define MCUIT_OP_NOP        5'h00
`define MCUIT_OP_ADD        5'h01
`define MCUIT_OP_ADDI       5'h02
`define MCUIT_OP_SUB        5'h03
`define MCUIT_OP_SUBI       5'h04
`define MCUIT_OP_AND        5'h05
`define MCUIT_OP_OR         5'h06
`define MCUIT_OP_XOR        5'h07
`define MCUIT_OP_CPL        5'h08
`define MCUIT_OP_INC        5'h09
`define MCUIT_OP_DEC        5'h0a
`define MCUIT_OP_RR         5'h0b
`define MCUIT_OP_RL         5'h0c
`define MCUIT_OP_RRC        5'h0d
`define MCUIT_OP_RLC        5'h0e
`define MCUIT_OP_MOVAM      5'h0f
`define MCUIT_OP_MOVMA      5'h10
`define MCUIT_OP_MOVI       5'h11
`define MCUIT_OP_SETB       5'h12
`define MCUIT_OP_CLRB       5'h13
`define MCUIT_OP_JMP        5'h14
`define MCUIT_OP_CALL       5'h15
`define MCUIT_OP_RET        5'h16
`define MCUIT_OP_SZ         5'h17
`define MCUIT_OP_SNZ        5'h18
`define MCUIT_OP_SZB        5'h19
`define MCUIT_OP_SNZB       5'h1a
`define MCUIT_OP_TABRD      5'h1b
`define MCUIT_OP_HALT       5'h1c

`endif

// ==== rtl/mcuit_pkg.sv ====
package mcuit_pkg;

	// position inside one instruction cycle
	typedef enum logic [1:0] {
		PH_ADDR,
		PH_WAIT,
		PH_FETCH,
		PH_COMMIT
	} mcuit_phase_e;

	typedef logic [4:0] mcuit_op_t;

	// status flags shown to the outside
	typedef struct packed {
		logic carry;
		logic zero;
	} mcuit_flags_s;

	// one data memory write
	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} mcuit_dwr_s;

endpackage

// ==== rtl/mcuit_dmem.sv ====
// data memory, registered read port, one write port
module mcuit_dmem #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	input  wire logic          ref_clk,
	input  wire logic          rst_b,
	input  wire logic          ce,
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata
);

	logic [DW-1:0] mem [2**AW];   // storage, no reset
	logic [DW-1:0] rdata_ff;      // read register

	// write port
	always_ff @(posedge ref_clk)
	begin
		if (ce && we)
		begin
			mem[waddr] <= wdata;
		end
	end

	// read port; old data on same-address write
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rdata_ff <= '0;
		end
		else if (ce)
		begin
			rdata_ff <= mem[raddr];
		end
	end

	assign rdata = rdata_ff;

endmodule

// ==== rtl/mcuit_core.sv ====
// How it works
// - one instruction cycle is four clocks
// - jump, call, table read take two
// - write to pc low byte jumps, extra cycle
// - skip taken costs one extra cycle
// - skips test byte or bit, skip next
// - call saves return, return resumes after call
// - carry above 255, borrow below zero
// - increment, decrement by one, either destination
// - logic ops set zero on zero result
// - rotates by one, some through carry
// - bit set/clear keeps other bits
// - table read pulls program word into registers
// - halt enters power-down
`include "mcuit_defines.svh"

module mcuit_core #(
	parameter int STACK_DEPTH = 4,
	parameter int PC_W        = 11
) (
	input  wire logic                ref_clk,
	input  wire logic                rst_b,
	input  wire logic                ce,
	output logic [PC_W-1:0]          prog_addr,
	input  wire logic [15:0]         prog_data,
	input  wire logic                wake,
	output logic [7:0]               acc,
	output mcuit_pkg::mcuit_flags_s  flags,
	output logic [PC_W-1:0]          pc,
	output logic                     power_down,
	output logic                     instr_done
);

	localparam int SPW = $clog2(STACK_DEPTH);

	mcuit_pkg::mcuit_phase_e ph_ff;          // clock within instruction cycle
	logic [PC_W-1:0]         pc_ff;          // address being fetched
	logic [PC_W-1:0]         prog_addr_ff;   // program memory address
	logic [15:0]             fetch_ff;       // word read this cycle
	logic [15:0]             instr_ff;       // instruction executing
	logic                    ivalid_ff;      // instr_ff not discarded
	logic [7:0]              acc_ff;         // accumulator
	mcuit_pkg::mcuit_flags_s flags_ff;       // carry and zero
	logic [7:0]              tblp_ff;        // table pointer
	logic [7:0]              tblh_ff;        // table high byte
	logic                    halted_ff;      // power-down
	logic                    done_ff;        // pulse after each commit
	logic [PC_W-1:0]         stk_ff [STACK_DEPTH];
	logic [SPW-1:0]          sp_ff;          // next free slot
	logic [7:0]              mem_rdata;      // data memory read
	mcuit_pkg::mcuit_dwr_s   dwr;            // data memory write

	mcuit_pkg::mcuit_op_t    op;
	logic [2:0]              bi;
	logic [7:0]              opm;
	logic [7:0]              mask;
	logic [7:0]              opnd;
	logic                    run;
	logic                    commit;

	// decode fields of the executing word
	assign op   = instr_ff[`MCUIT_OP_MSB:`MCUIT_OP_LSB];
	assign bi   = instr_ff[`MCUIT_BIT_MSB:`MCUIT_BIT_LSB];
	assign opm  = instr_ff[`MCUIT_OPND_MSB:0];
	assign mask = 8'h01 << bi;
	assign run    = ce && !halted_ff;
	assign commit = run && (ph_ff == mcuit_pkg::PH_COMMIT);

	// special registers sit over data memory
	always_comb
	begin
		case (opm)
			`MCUIT_PCL_ADDR:  opnd = pc_ff[7:0];
			`MCUIT_TBLP_ADDR: opnd = tblp_ff;
			`MCUIT_TBLH_ADDR: opnd = tblh_ff;
			default:          opnd = mem_rdata;
		endcase
	end

	// execute; results only take effect at commit
	logic [7:0]      res;
	logic            nc;
	logic            nz;
	logic            dst;        // result goes to d-selected place
	logic            wr_acc;
	logic            wr_mem;
	logic            skip_take;
	logic            redirect;
	logic [PC_W-1:0] tgt;
	logic            push;
	logic            pop;
	logic            tab;
	logic            halt;
	logic            pcl_wr;
	always_comb
	begin
		res       = opnd;
		nc        = flags_ff.carry;
		nz        = flags_ff.zero;
		dst       = 1'b0;
		wr_acc    = 1'b0;
		wr_mem    = 1'b0;
		skip_take = 1'b0;
		redirect  = 1'b0;
		tgt       = instr_ff[`MCUIT_TGT_MSB:0];
		push      = 1'b0;
		pop       = 1'b0;
		tab       = 1'b0;
		halt      = 1'b0;
		case (op)
			`MCUIT_OP_ADD:   {nc, res} = {1'b0, acc_ff} + {1'b0, opnd};
			`MCUIT_OP_ADDI:  {nc, res} = {1'b0, acc_ff} + {1'b0, opm};
			`MCUIT_OP_SUB:
			begin
				res = acc_ff - opnd;
				nc  = acc_ff < opnd;
			end
			`MCUIT_OP_SUBI:
			begin
				res = acc_ff - opm;
				nc  = acc_ff < opm;
			end
			`MCUIT_OP_AND:   res = acc_ff & opnd;
			`MCUIT_OP_OR:    res = acc_ff | opnd;
			`MCUIT_OP_XOR:   res = acc_ff ^ opnd;
			`MCUIT_OP_CPL:   res = ~opnd;
			`MCUIT_OP_INC:   res = opnd + 8'h01;
			`MCUIT_OP_DEC:   res = opnd - 8'h01;
			`MCUIT_OP_RR:    res = {opnd[0], opnd[7:1]};
			`MCUIT_OP_RL:    res = {opnd[6:0], opnd[7]};
			`MCUIT_OP_RRC:
			begin
				res = {flags_ff.carry, opnd[7:1]};
				nc  = opnd[0];
			end
			`MCUIT_OP_RLC:
			begin
				res = {opnd[6:0], flags_ff.carry};
				nc  = opnd[7];
			end
			`MCUIT_OP_MOVAM: wr_acc = 1'b1;
			`MCUIT_OP_MOVMA:
			begin
				res    = acc_ff;
				wr_mem = 1'b1;
			end
			`MCUIT_OP_MOVI:
			begin
				res    = opm;
				wr_acc = 1'b1;
			end
			// read-modify-write of one bit
			`MCUIT_OP_SETB:
			begin
				res    = opnd | mask;
				wr_mem = 1'b1;
			end
			`MCUIT_OP_CLRB:
			begin
				res    = opnd & ~mask;
				wr_mem = 1'b1;
			end
			`MCUIT_OP_JMP:   redirect = 1'b1;
			`MCUIT_OP_CALL:
			begin
				redirect = 1'b1;
				push     = 1'b1;
			end
			`MCUIT_OP_RET:
			begin
				redirect = 1'b1;
				pop      = 1'b1;
				tgt      = stk_ff[sp_ff - SPW'(1)];
			end
			`MCUIT_OP_SZ:    skip_take = (opnd == 8'h00);
			`MCUIT_OP_SNZ:   skip_take = (opnd != 8'h00);
			`MCUIT_OP_SZB:   skip_take = !opnd[bi];
			`MCUIT_OP_SNZB:  skip_take = opnd[bi];
			// low byte to memory, high byte held
			`MCUIT_OP_TABRD:
			begin
				res    = fetch_ff[7:0];
				wr_mem = 1'b1;
				tab    = 1'b1;
			end
			`MCUIT_OP_HALT:  halt = 1'b1;
			default:         ;
		endcase
		// d bit picks memory or accumulator
		case (op)
			`MCUIT_OP_ADD, `MCUIT_OP_SUB, `MCUIT_OP_AND, `MCUIT_OP_OR, `MCUIT_OP_XOR, `MCUIT_OP_CPL,
			`MCUIT_OP_INC, `MCUIT_OP_DEC, `MCUIT_OP_RR, `MCUIT_OP_RL, `MCUIT_OP_RRC, `MCUIT_OP_RLC:
				dst = 1'b1;
			default:
				dst = 1'b0;
		endcase
		// zero flag on arithmetic, logic and inc/dec
		case (op)
			`MCUIT_OP_ADD, `MCUIT_OP_ADDI, `MCUIT_OP_SUB, `MCUIT_OP_SUBI, `MCUIT_OP_AND, `MCUIT_OP_OR,
			`MCUIT_OP_XOR, `MCUIT_OP_CPL, `MCUIT_OP_INC, `MCUIT_OP_DEC:
				nz = (res == 8'h00);
			default:
				nz = flags_ff.zero;
		endcase
		wr_mem = wr_mem || (dst && instr_ff[`MCUIT_DST_BIT]);
		wr_acc = wr_acc || (dst && !instr_ff[`MCUIT_DST_BIT]) || (op == `MCUIT_OP_ADDI) || (op == `MCUIT_OP_SUBI);
		pcl_wr = wr_mem && (opm == `MCUIT_PCL_ADDR);
		if (pcl_wr)
		begin
			redirect = 1'b1;
			tgt      = {pc_ff[PC_W-1:8], res};
		end
		if (skip_take)
		begin
			redirect = 1'b1;
			tgt      = pc_ff + PC_W'(1);
		end
	end

	// data memory port; special addresses are not stored
	assign dwr.en   = commit && ivalid_ff && wr_mem && (opm != `MCUIT_PCL_ADDR) &&
	                  (opm != `MCUIT_TBLP_ADDR) && (opm != `MCUIT_TBLH_ADDR);
	assign dwr.addr = opm;
	assign dwr.data = res;

	mcuit_dmem #(
		.AW (8),
		.DW (8)
	) u_dmem (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.ce      (ce),
		.raddr   (opm),
		.rdata   (mem_rdata),
		.we      (dwr.en),
		.waddr   (dwr.addr),
		.wdata   (dwr.data)
	);

	// four clocks per instruction cycle, frozen in halt
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ph_ff <= mcuit_pkg::PH_ADDR;
		end
		else if (run)
		begin
			case (ph_ff)
				mcuit_pkg::PH_ADDR:   ph_ff <= mcuit_pkg::PH_WAIT;
				mcuit_pkg::PH_WAIT:   ph_ff <= mcuit_pkg::PH_FETCH;
				mcuit_pkg::PH_FETCH:  ph_ff <= mcuit_pkg::PH_COMMIT;
				mcuit_pkg::PH_COMMIT: ph_ff <= mcuit_pkg::PH_ADDR;
				default:              ph_ff <= mcuit_pkg::PH_ADDR;
			endcase
		end
	end

	// program address: table slot steals the fetch
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			prog_addr_ff <= `MCUIT_PC_RST;
		end
		else if (run && ph_ff == mcuit_pkg::PH_ADDR)
		begin
			if (ivalid_ff && op == `MCUIT_OP_TABRD)
			begin
				prog_addr_ff <= {pc_ff[PC_W-1:8], tblp_ff};
			end
			else
			begin
				prog_addr_ff <= pc_ff;
			end
		end
	end

	// program word sampled two clocks after the address
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			fetch_ff <= 16'h0000;
		end
		else if (run && ph_ff == mcuit_pkg::PH_FETCH)
		begin
			fetch_ff <= prog_data;
		end
	end

	// pc and prefetch pipeline
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pc_ff     <= `MCUIT_PC_RST;
			instr_ff  <= 16'h0000;
			ivalid_ff <= 1'b0;
		end
		else if (commit)
		begin
			instr_ff <= fetch_ff;
			if (ivalid_ff && redirect)
			begin
				pc_ff     <= tgt;
				ivalid_ff <= 1'b0;
			end
			else if (ivalid_ff && tab)
			begin
				ivalid_ff <= 1'b0;
			end
			else
			begin
				pc_ff     <= pc_ff + PC_W'(1);
				ivalid_ff <= 1'b1;
			end
		end
	end

	// accumulator, flags, table registers
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			acc_ff   <= `MCUIT_ACC_RST;
			flags_ff <= '0;
			tblp_ff  <= 8'h00;
			tblh_ff  <= 8'h00;
		end
		else if (commit && ivalid_ff)
		begin
			flags_ff.carry <= nc;
			flags_ff.zero  <= nz;
			if (wr_acc)
			begin
				acc_ff <= res;
			end
			if (wr_mem && opm == `MCUIT_TBLP_ADDR)
			begin
				tblp_ff <= res;
			end
			if (tab)
			begin
				tblh_ff <= fetch_ff[15:8];
			end
			else if (wr_mem && opm == `MCUIT_TBLH_ADDR)
			begin
				tblh_ff <= res;
			end
		end
	end

	// return stack, wraps when overfilled
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sp_ff <= '0;
			for (int i = 0; i < STACK_DEPTH; i++)
			begin
				stk_ff[i] <= '0;
			end
		end
		else if (commit && ivalid_ff)
		begin
			if (push)
			begin
				stk_ff[sp_ff] <= pc_ff;
				sp_ff         <= sp_ff + SPW'(1);
			end
			else if (pop)
			begin
				sp_ff <= sp_ff - SPW'(1);
			end
		end
	end

	// power-down until wake
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			halted_ff <= 1'b0;
			done_ff   <= 1'b0;
		end
		else if (ce)
		begin
			done_ff <= commit;
			if (commit && ivalid_ff && halt)
			begin
				halted_ff <= 1'b1;
			end
			else if (wake)
			begin
				halted_ff <= 1'b0;
			end
		end
	end

	assign prog_addr  = prog_addr_ff;
	assign acc        = acc_ff;
	assign flags      = flags_ff;
	assign pc         = pc_ff;
	assign power_down = halted_ff;
	assign instr_done = done_ff;

	a_cycle_four: assert property (@(posedge ref_clk) disable iff (!rst_b || !ce)
		commit && !(ivalid_ff && halt) |=> !commit[*3] ##1 commit) else $error("cycle not four clocks");
	a_jump_target: assert property (@(posedge ref_clk) disable iff (!rst_b || !ce)
		commit && ivalid_ff && op == `MCUIT_OP_JMP |=> pc_ff == $past(instr_ff[10:0]) && !ivalid_ff)
		else $error("jump target wrong");
	a_redirect_drop: assert property (@(posedge ref_clk) disable iff (!rst_b || !ce)
		commit && ivalid_ff && redirect |=> (!ivalid_ff)[*4]) else $error("prefetch not discarded");
	a_pcl_jump: assert property (@(posedge ref_clk) disable iff (!rst_b || !ce)
		commit && ivalid_ff && pcl_wr |=> pc_ff[7:0] == $past(res) && !ivalid_ff) else $error("pcl write no jump");
	a_skip_taken: assert property (@(posedge ref_clk) disable iff (!rst_b || !ce)
		commit && ivalid_ff && skip_take |=> pc_ff == $past(pc_ff) + PC_W'(1) && !ivalid_ff)
		else $error("skip not taken");
	a_skip_not: assert property (@(posedge ref_clk) disable iff (!rst_b || !ce)
		commit && ivalid_ff && op == `MCUIT_OP_SZ && opnd != 8'h00 |=> ivalid_ff) else $error("false skip");
	a_return_point: assert property (@(posedge ref_clk) disable iff (!rst_b || !ce)
		commit && ivalid_ff && op == `MCUIT_OP_CALL |=> stk_ff[$past(sp_ff)] == $past(pc_ff))
		else $error("return point lost");
	a_add_carry: assert property (@(posedge ref_clk) disable iff (!rst_b || !ce)
		commit && ivalid_ff && op == `MCUIT_OP_ADD |=>
		flags_ff.carry == (({1'b0, $past(acc_ff)} + {1'b0, $past(opnd)}) > 9'h0ff)) else $error("add carry wrong");
	a_sub_borrow: assert property (@(posedge ref_clk) disable iff (!rst_b || !ce)
		commit && ivalid_ff && op == `MCUIT_OP_SUBI |=> flags_ff.carry == ($past(acc_ff) < $past(opm)))
		else $error("sub borrow wrong");
	a_inc_acc: assert property (@(posedge ref_clk) disable iff (!rst_b || !ce)
		commit && ivalid_ff && op == `MCUIT_OP_INC && !instr_ff[8] |=> acc_ff == $past(opnd) + 8'h01)
		else $error("increment wrong");
	a_zero_logic: assert property (@(posedge ref_clk) disable iff (!rst_b || !ce)
		commit && ivalid_ff && op == `MCUIT_OP_AND |=> flags_ff.zero == (($past(acc_ff) & $past(opnd)) == 8'h00))
		else $error("zero flag wrong");
	a_rotate_carry: assert property (@(posedge ref_clk) disable iff (!rst_b || !ce)
		commit && ivalid_ff && op == `MCUIT_OP_RRC |=> flags_ff.carry == $past(opnd[0])) else $error("rrc carry");
	a_bit_keep: assert property (@(posedge ref_clk) disable iff (!rst_b || !ce)
		dwr.en && (op == `MCUIT_OP_SETB || op == `MCUIT_OP_CLRB) |-> (dwr.data & ~mask) == (opnd & ~mask))
		else $error("other bits changed");
	a_table_addr: assert property (@(posedge ref_clk) disable iff (!rst_b || !ce)
		commit && ivalid_ff && tab |-> prog_addr_ff == {pc_ff[PC_W-1:8], tblp_ff}) else $error("table address");
	a_halt_down: assert property (@(posedge ref_clk) disable iff (!rst_b || !ce)
		commit && ivalid_ff && halt |=> power_down) else $error("halt ignored");

endmodule

// ==== test/mcuit_prog_mem.sv ====
// program memory seen by the core, loaded by the bench while the core sits in reset
module mcuit_prog_mem (
	input  wire logic        ref_clk,
	input  wire logic [10:0] prog_addr,
	output logic      [15:0] prog_data,
	input  wire logic        ld_en,
	input  wire logic [5:0]  ld_addr,
	input  wire logic [15:0] ld_data
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [15:0] mem_q [64]; // code and table words
	logic [10:0] addr_q;     // registered address

	// load port, bench side only
	always @(posedge ref_clk)
	begin
		if (ld_en)
			mem_q[ld_addr] <= ld_data;
	end

	// one clock of read latency, the slower of the two the core accepts;
	// the old word stays visible for that clock, as real memory would do
	always @(posedge ref_clk)
	begin
		addr_q <= prog_addr;
	end

	// outside the loaded area the word reads as a plain no-op
	assign prog_data = (addr_q[10:6] == 5'h00) ? mem_q[addr_q[5:0]] : 16'h0000;
endmodule

// ==== test/test_mcuit_core.sv ====
// self-checking bench: table of one-instruction programs, then hand tests
module test_mcuit_core;
	timeunit 1ns;
	timeprecision 100ps;

	// one row: a test instruction with its presets and the expected outcome
	typedef struct packed {
		logic [4:0] op;   // opcode under test
		logic [2:0] b;    // bit index, or destination in bit 0
		logic [7:0] lo;   // address or immediate
		logic [7:0] mem;  // preset of data byte 0x10
		logic [7:0] acc;  // preset accumulator
		logic [1:0] post; // 0 no-op, 1 read 0x10, 2 load 0xee
		logic [7:0] ea;   // expected accumulator
		logic       c;    // expected carry
		logic       z;    // expected zero
		logic [3:0] sl;   // instruction cycles up to the halt
	} mcuit_row_s;

	logic                    ref_clk;
	logic                    rst_b;
	logic                    ce;
	logic                    wake;
	logic                    ld_en;
	logic [5:0]              ld_addr;
	logic [15:0]             ld_data;
	logic [15:0]             prog_data;
	logic [10:0]             prog_addr;
	logic [10:0]             pc;
	logic [10:0]             pc_seen;
	logic [7:0]              acc;
	mcuit_pkg::mcuit_flags_s flags;
	logic                    power_down;
	logic                    instr_done;
	int                      fail_count;
	int                      compares;
	int                      cyc;
	int                      gap;
	int                      t;
	int                      t0;
	int                      i;
	logic [15:0]             prog [64];

	// base cycle count is six: three presets, the test word, the post word, halt
	mcuit_row_s rows [26] = '{
		'{5'h01, 3'h0, 8'h10, 8'h20, 8'hf0, 2'd0, 8'h10, 1'b1, 1'b0, 4'd6},
		'{5'h01, 3'h0, 8'h10, 8'h80, 8'h80, 2'd0, 8'h00, 1'b1, 1'b1, 4'd6},
		'{5'h02, 3'h0, 8'h01, 8'h00, 8'hff, 2'd0, 8'h00, 1'b1, 1'b1, 4'd6},
		'{5'h03, 3'h0, 8'h10, 8'h06, 8'h05, 2'd0, 8'hff, 1'b1, 1'b0, 4'd6},
		'{5'h04, 3'h0, 8'h06, 8'h00, 8'h06, 2'd0, 8'h00, 1'b0, 1'b1, 4'd6},
		'{5'h05, 3'h0, 8'h10, 8'h0f, 8'hf0, 2'd0, 8'h00, 1'b0, 1'b1, 4'd6},
		'{5'h06, 3'h0, 8'h10, 8'h03, 8'h30, 2'd0, 8'h33, 1'b0, 1'b0, 4'd6},
		'{5'h07, 3'h0, 8'h10, 8'h5a, 8'h5a, 2'd0, 8'h00, 1'b0, 1'b1, 4'd6},
		'{5'h08, 3'h1, 8'h10, 8'hff, 8'h00, 2'd1, 8'h00, 1'b0, 1'b1, 4'd6},
		'{5'h09, 3'h1, 8'h10, 8'hff, 8'h00, 2'd1, 8'h00, 1'b0, 1'b1, 4'd6},
		'{5'h09, 3'h0, 8'h10, 8'h41, 8'h00, 2'd0, 8'h42, 1'b0, 1'b0, 4'd6},
		'{5'h0a, 3'h0, 8'h10, 8'h01, 8'h00, 2'd0, 8'h00, 1'b0, 1'b1, 4'd6},
		'{5'h0a, 3'h1, 8'h10, 8'h00, 8'h00, 2'd1, 8'hff, 1'b0, 1'b0, 4'd6},
		'{5'h0b, 3'h0, 8'h10, 8'h01, 8'h00, 2'd0, 8'h80, 1'b0, 1'b0, 4'd6},
		'{5'h0c, 3'h0, 8'h10, 8'h81, 8'h00, 2'd0, 8'h03, 1'b0, 1'b0, 4'd6},
		'{5'h0d, 3'h0, 8'h10, 8'h01, 8'h00, 2'd0, 8'h00, 1'b1, 1'b0, 4'd6},
		'{5'h0e, 3'h1, 8'h10, 8'h80, 8'h00, 2'd1, 8'h00, 1'b1, 1'b0, 4'd6},
		'{5'h12, 3'h3, 8'h10, 8'ha0, 8'h00, 2'd1, 8'ha8, 1'b0, 1'b0, 4'd6},
		'{5'h13, 3'h7, 8'h10, 8'hff, 8'h00, 2'd1, 8'h7f, 1'b0, 1'b0, 4'd6},
		'{5'h17, 3'h0, 8'h10, 8'h00, 8'h11, 2'd2, 8'h11, 1'b0, 1'b0, 4'd6},
		'{5'h17, 3'h0, 8'h10, 8'h01, 8'h11, 2'd2, 8'hee, 1'b0, 1'b0, 4'd6},
		'{5'h18, 3'h0, 8'h10, 8'h01, 8'h11, 2'd2, 8'h11, 1'b0, 1'b0, 4'd6},
		'{5'h19, 3'h2, 8'h10, 8'hfb, 8'h11, 2'd2, 8'h11, 1'b0, 1'b0, 4'd6},
		'{5'h1a, 3'h2, 8'h10, 8'hfb, 8'h11, 2'd2, 8'hee, 1'b0, 1'b0, 4'd6},
		'{5'h14, 3'h0, 8'h04, 8'h00, 8'h11, 2'd2, 8'hee, 1'b0, 1'b0, 4'd7},
		'{5'h10, 3'h0, 8'h06, 8'h00, 8'h05, 2'd2, 8'h05, 1'b0, 1'b0, 4'd6}
	};

	mcuit_core u_mcuit_core (
		.ref_clk    (ref_clk),
		.rst_b      (rst_b),
		.ce         (ce),
		.prog_addr  (prog_addr),
		.prog_data  (prog_data),
		.wake       (wake),
		.acc        (acc),
		.flags      (flags),
		.pc         (pc),
		.power_down (power_down),
		.instr_done (instr_done)
	);

	mcuit_prog_mem u_mcuit_prog_mem (
		.ref_clk   (ref_clk),
		.prog_addr (prog_addr),
		.prog_data (prog_data),
		.ld_en     (ld_en),
		.ld_addr   (ld_addr),
		.ld_data   (ld_data)
	);

	// 25 MHz; the core only counts clocks, whatever rate the oscillator was set to
	initial ref_clk = 1'b0;
	always #20 ref_clk = ~ref_clk;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		if (fail_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// load n words under reset, release, count clocks until the core halts
	task automatic run(input int n, output int tt);
		int k;
		@(posedge ref_clk);
		rst_b <= 1'b0;
		for (k = 0; k < n; k++)
		begin
			@(posedge ref_clk);
			ld_en   <= 1'b1;
			ld_addr <= 6'(k);
			ld_data <= prog[k];
		end
		@(posedge ref_clk);
		ld_en <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		tt = 0;
		@(negedge ref_clk);
		while (power_down !== 1'b1 && tt < 300)
		begin
			@(negedge ref_clk);
			tt++;
		end
		check(16'(power_down), 16'h0001);
	endtask

	// presets, test word, post word, halt
	task automatic fill(input mcuit_row_s r);
		prog[0] = {5'h11, 3'h0, r.mem};
		prog[1] = 16'h8010;
		prog[2] = {5'h11, 3'h0, r.acc};
		prog[3] = {r.op, r.b, r.lo};
		prog[4] = (r.post == 2'd1) ? 16'h7810 : (r.post == 2'd2) ? 16'h88ee : 16'h0000;
		prog[5] = 16'he000;
	endtask

	// completions must come every four clocks while running freely;
	// stalls and halts restart the count since they stretch a cycle on purpose
	always @(negedge ref_clk)
	begin
		if (rst_b !== 1'b1 || power_down !== 1'b0 || ce !== 1'b1)
			gap = 0;
		else if (instr_done === 1'b1)
		begin
			if (gap != 0)
				check(16'(gap), 16'd4);
			gap = 1;
		end
		else if (gap != 0)
			gap++;
	end

	// hang guard, far above the roughly 1200 clocks the run needs
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			fail_count++;
			stop_test();
		end
	end

	initial
	begin
		rst_b = 1'b0;
		ce = 1'b1;
		wake = 1'b0;
		ld_en = 1'b0;
		ld_addr = 6'h00;
		ld_data = 16'h0000;
		fail_count = 0;
		compares = 0;
		cyc = 0;
		gap = 0;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		check(16'(acc), 16'h0000);
		check(16'(pc), 16'h0000);
		check(16'(prog_addr), 16'h0000);
		check(16'({flags, power_down, instr_done}), 16'h0000);
		// ordinary cases, first row sets the base clock count
		for (i = 0; i < 26; i++)
		begin
			fill(rows[i]);
			run(6, t);
			if (i == 0)
				t0 = t;
			check(16'(acc), 16'(rows[i].ea));
			check(16'({flags.carry, flags.zero}), 16'({rows[i].c, rows[i].z}));
			check(16'(t - t0), 16'(4 * (rows[i].sl - 6)));
		end
		// call to 4, add 1 there, return to 1, add 0x10, halt
		prog[0] = 16'ha804;
		prog[1] = 16'h1010;
		prog[2] = 16'he000;
		prog[3] = 16'h0000;
		prog[4] = 16'h1001;
		prog[5] = 16'hb000;
		run(6, t);
		check(16'(acc), 16'h0011);
		check(16'(t - t0), 16'd4);
		// table word at 0x20: low byte to 0x10, high byte to the table latch
		prog[0] = 16'h8820;
		prog[1] = 16'h8007;
		prog[2] = 16'hd810;
		prog[3] = 16'h7810;
		prog[4] = 16'h3808;
		prog[5] = 16'he000;
		prog[32] = 16'ha55a;
		run(33, t);
		check(16'(acc), 16'h00ff);
		check(16'(t - t0), 16'd4);
		// halt first, then wake, with a clock-enable stall in mid-run
		prog[0] = 16'he000;
		prog[1] = 16'h885a;
		prog[2] = 16'he000;
		run(3, t);
		pc_seen = pc;
		repeat (8) @(negedge ref_clk);
		check(16'(pc), 16'(pc_seen));
		check(16'({acc, instr_done}), 16'h0000);
		@(posedge ref_clk);
		wake <= 1'b1;
		t = 0;
		@(negedge ref_clk);
		while (power_down !== 1'b0 && t < 8)
		begin
			@(negedge ref_clk);
			t++;
		end
		check(16'(power_down), 16'h0000);
		@(posedge ref_clk);
		wake <= 1'b0;
		ce <= 1'b0;
		@(negedge ref_clk);
		pc_seen = pc;
		repeat (5) @(posedge ref_clk);
		ce <= 1'b1;
		// the edge that raised ce still saw it low, so pc must be unchanged here
		@(negedge ref_clk);
		check(16'(pc), 16'(pc_seen));
		t = 0;
		@(negedge ref_clk);
		while (power_down !== 1'b1 && t < 40)
		begin
			@(negedge ref_clk);
			t++;
		end
		check(16'({acc, 7'h00, power_down}), 16'h5a01);
		stop_test();
	end
endmodule
